// >>> verilog/data_space_access_unit.sv
// data-space access unit: byte addressing, ram and window routing, traps,
// stack checks and secure ram gating for a 16-bit core
// assumes one access request per cycle from the pipeline, answered two cycles later
//
// How it works
// - effective byte address is 16 bits, covering 64 KB or 32K words
// - bit 15 clear goes to data memory, set goes to program window
// - reads outside implemented 2 KB memory return zero, byte or word
// - low byte sits at even address, high byte at odd address
// - post-increment adds 1 for byte, 2 for word operations
// - byte read fetches whole word, bit 0 picks lane, result in low byte
// - shared word decode with per-byte strobes; byte write touches one lane
// - word access at odd address raises address error, no unaligned transfer
// - misaligned read completes, misaligned write suppressed, trap follows
// - byte load into working register changes only its low byte
// - sign-extend widens 8 to 16 bits; zero-extend clears high byte
// - 0x0000 to 0x07FF hold special registers; unimplemented ones read zero
// - memory-direct near field of 13 bits reaches 0x0000 to 0x1FFF
// - move instructions reach whole space directly or through a pointer
// - stack pointer names next free word, post-increments push, pre-decrements pop
// - plain push stores the write data unchanged; only exception push clears bit 7 of its word
// - exception push puts status low byte in upper word's top byte
// - stack limit has no reset value and its bit 0 reads zero
// - push at limit is fine, the push beyond the limit traps
// - stack address below 0x0800 raises stack error trap
// - secure ram segments are reachable only from their own flash segment
// - 8-bit page register selects program region seen in upper 32 KB
`timescale 1ns/1ns
`default_nettype none
module data_space_access_unit #(
  parameter int RAM_WORDS = dsau_pkg::RAM_WORDS,
  parameter int IDX_W     = dsau_pkg::WORD_IDX_W
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // access request from pipeline
  input  wire logic        i_valid,
  input  wire logic [2:0]  i_op,
  input  wire logic [1:0]  i_amode,
  input  wire logic        i_byte_op,
  input  wire logic [15:0] i_addr_field,
  input  wire logic [15:0] i_source_pointer_reg,
  input  wire logic [15:0] i_wdata,
  input  wire logic [15:0] i_dest_reg_old,
  input  wire logic        i_exception_push,
  input  wire logic [22:0] i_pc,
  input  wire logic [7:0]  i_status_low_byte,
  // special region from peripherals
  input  wire logic [15:0] i_sfr_rdata,
  input  wire logic        i_sfr_hit,
  // program window and security
  input  wire logic [7:0]  i_program_window_page,
  input  wire logic [15:0] i_prog_rdata,
  input  wire logic        i_boot_ram_en,
  input  wire logic [15:0] i_boot_ram_start,
  input  wire logic        i_app_ram_en,
  input  wire logic [15:0] i_app_ram_start,
  input  wire logic        i_exec_boot_seg,
  input  wire logic        i_exec_app_seg,
  // trap handshake
  input  wire logic        i_addr_trap_ack,
  input  wire logic        i_stack_trap_ack,
  // answer to pipeline
  output logic             o_done,
  output logic [15:0]      o_rdata,
  output logic [15:0]      o_reg_result,
  output logic [15:0]      o_source_pointer_next,
  output logic [15:0]      o_stack_pointer_reg,
  output logic [15:0]      o_stack_limit_reg,
  output logic [22:0]      o_prog_addr,
  output logic             o_prog_rd,
  // special region port
  output logic [15:0]      o_sfr_addr,
  output logic [1:0]       o_sfr_we,
  output logic             o_sfr_rd,
  output logic [15:0]      o_sfr_wdata,
  // trap requests
  output logic             o_addr_trap,
  output logic             o_stack_trap
);
  logic        rst_m_q, rst_s_q;
  logic [15:0] ea, sp_addr, push_word;
  logic        is_window, is_ram, is_sfr, misalign;
  logic        rd_op, wr_op, push_op, pop_op, denied;
  logic        stack_err, addr_err_q, stack_err_q;
  logic [1:0]  lane_we;
  logic [IDX_W-1:0] widx;
  logic [7:0]  ram_lo [RAM_WORDS];
  logic [7:0]  ram_hi [RAM_WORDS];
  logic [15:0] word_sel, rd_fmt;
  logic [15:0] sp_q, lim_q;
  logic        done_q, rd_q, lsb_q, byte_q, window_q, ram_q, sfr_q, zero_q;
  logic [15:0] ram_word_q, old_q;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  assign rd_op   = i_valid && (i_op == dsau_pkg::OP_READ);
  assign wr_op   = i_valid && (i_op == dsau_pkg::OP_WRITE);
  assign push_op = i_valid && (i_op == dsau_pkg::OP_PUSH);
  assign pop_op  = i_valid && (i_op == dsau_pkg::OP_POP);
  assign sp_addr = pop_op ? (sp_q - dsau_pkg::WORD_STEP) : sp_q;

  // effective 16-bit byte address per mode
  always_comb begin
    case (i_amode)
      dsau_pkg::AM_NEAR:   ea = {{(16-dsau_pkg::NEAR_W){1'b0}},
                                 i_addr_field[dsau_pkg::NEAR_W-1:0]};
      dsau_pkg::AM_DIRECT: ea = i_addr_field;
      default:             ea = i_source_pointer_reg;
    endcase
    if (push_op || pop_op) ea = sp_addr;
  end

  // window on bit 15; special region; past ram is empty
  assign is_window = ea[dsau_pkg::WINDOW_BIT];
  assign is_sfr    = !is_window && (ea <= dsau_pkg::SFR_LAST);
  assign is_ram    = !is_window && !is_sfr && (ea < dsau_pkg::RAM_END);
  // word access at an odd address
  assign misalign  = !i_byte_op && ea[0] && (rd_op || wr_op);

  // secure ram gating, segment from its start up to ram end
  assign denied = (i_boot_ram_en && is_ram && ea >= i_boot_ram_start && !i_exec_boot_seg)
               || (i_app_ram_en && is_ram && ea >= i_app_ram_start && !i_exec_app_seg
                   && !(i_boot_ram_en && ea >= i_boot_ram_start));

  always_comb begin
    lane_we = 2'b00;
    if ((wr_op || push_op) && !misalign) begin
      if (push_op || !i_byte_op) lane_we = 2'b11;
      else lane_we = ea[0] ? 2'b10 : 2'b01; // odd byte is high lane
    end
  end

  // plain push passes write data; exception clears bit 7 and merges status byte
  always_comb begin
    push_word = i_wdata;
    if (i_exception_push) push_word = {i_status_low_byte, 1'b0, i_pc[22:16]};
  end

  assign widx = ea[IDX_W:1];

  // ram lanes, one write strobe each
  genvar g;
  for (g = 0; g < 2; g++) begin : g_lane
    // each lane array has exactly one writing process
    if (g == 0) begin : g_lo
      always_ff @(posedge i_clk) begin
        if (lane_we[g] && is_ram && !denied) begin
          ram_lo[widx] <= i_byte_op ? i_wdata[7:0] : push_word[7:0];
        end
      end
    end else begin : g_hi
      always_ff @(posedge i_clk) begin
        if (lane_we[g] && is_ram && !denied) begin
          ram_hi[widx] <= i_byte_op ? i_wdata[7:0] : push_word[15:8];
        end
      end
    end
  end

  assign stack_err = (push_op && (sp_q > lim_q))
                  || ((push_op || pop_op) && (sp_addr < dsau_pkg::RAM_FIRST));

  // stack pointer: post-increment push, pre-decrement pop
  always_ff @(posedge i_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      sp_q <= dsau_pkg::RAM_FIRST;
    end else if (push_op) begin
      sp_q <= sp_q + dsau_pkg::WORD_STEP;
    end else if (pop_op) begin
      sp_q <= sp_addr;
    end
  end

  // limit is not reset, bit 0 forced low
  always_ff @(posedge i_clk) begin
    if (i_valid && i_op == dsau_pkg::OP_SETLIM) lim_q <= i_wdata & dsau_pkg::ALIGN_MASK;
  end

  // registered answer state
  always_ff @(posedge i_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      done_q   <= 1'b0;
      rd_q     <= 1'b0;
      lsb_q    <= 1'b0;
      byte_q   <= 1'b0;
      window_q <= 1'b0;
      ram_q    <= 1'b0;
      sfr_q    <= 1'b0;
      zero_q   <= 1'b0;
      old_q    <= dsau_pkg::ZERO_WORD;
      ram_word_q <= dsau_pkg::ZERO_WORD;
    end else begin
      done_q   <= i_valid;
      rd_q     <= rd_op || pop_op || i_op == dsau_pkg::OP_SEXT || i_op == dsau_pkg::OP_ZEXT;
      lsb_q    <= ea[0];
      byte_q   <= i_byte_op;
      window_q <= is_window;
      ram_q    <= is_ram && !denied;
      sfr_q    <= is_sfr; // hit only comes back with the strobe, a cycle later
      zero_q   <= misalign;
      old_q    <= (i_op == dsau_pkg::OP_SEXT || i_op == dsau_pkg::OP_ZEXT)
                  ? i_wdata : i_dest_reg_old;
      // the whole containing word is fetched
      ram_word_q <= {ram_hi[widx], ram_lo[widx]};
    end
  end

  // unimplemented reads as zero; word before lane pick
  always_comb begin
    // a misaligned read completes but hands back zero
    if (zero_q) word_sel = dsau_pkg::ZERO_WORD;
    else if (window_q) word_sel = i_prog_rdata;
    else if (ram_q) word_sel = ram_word_q;
    else if (sfr_q && i_sfr_hit) word_sel = i_sfr_rdata;
    else word_sel = dsau_pkg::ZERO_WORD;
    // selected byte onto the low lane
    if (byte_q) word_sel = {dsau_pkg::ZERO_BYTE, lsb_q ? word_sel[15:8] : word_sel[7:0]};
  end

  assign rd_fmt = word_sel;

  // answer outputs
  always_ff @(posedge i_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      o_done       <= 1'b0;
      o_rdata      <= dsau_pkg::ZERO_WORD;
      o_reg_result <= dsau_pkg::ZERO_WORD;
    end else begin
      o_done  <= done_q;
      o_rdata <= rd_q ? rd_fmt : dsau_pkg::ZERO_WORD; // writes, pushes and limit sets show zero
      if (i_op == dsau_pkg::OP_SEXT && i_valid) begin
        o_reg_result <= {{8{i_wdata[7]}}, i_wdata[7:0]};
      end else if (i_op == dsau_pkg::OP_ZEXT && i_valid) begin
        o_reg_result <= {dsau_pkg::ZERO_BYTE, i_wdata[7:0]};
      end else if (byte_q) begin
        o_reg_result <= {old_q[15:8], rd_fmt[7:0]};
      end else begin
        o_reg_result <= rd_fmt;
      end
    end
  end

  // pointer, stack and window outputs
  always_ff @(posedge i_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      o_source_pointer_next <= dsau_pkg::ZERO_WORD;
      o_stack_pointer_reg   <= dsau_pkg::RAM_FIRST;
      o_stack_limit_reg     <= dsau_pkg::ZERO_WORD;
      o_prog_addr           <= '0;
      o_prog_rd             <= 1'b0;
    end else begin
      o_source_pointer_next <= (i_amode == dsau_pkg::AM_POSTINC)
        ? i_source_pointer_reg + (i_byte_op ? dsau_pkg::BYTE_STEP : dsau_pkg::WORD_STEP)
        : i_source_pointer_reg;
      o_stack_pointer_reg   <= push_op ? sp_q + dsau_pkg::WORD_STEP : (pop_op ? sp_addr : sp_q);
      o_stack_limit_reg     <= lim_q & dsau_pkg::ALIGN_MASK; // even before any write
      o_prog_addr <= {i_program_window_page, ea[14:1], 1'b0};
      o_prog_rd   <= (rd_op || pop_op) && is_window;
    end
  end

  // special region port
  always_ff @(posedge i_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      o_sfr_addr  <= dsau_pkg::ZERO_WORD;
      o_sfr_we    <= 2'b00;
      o_sfr_rd    <= 1'b0;
      o_sfr_wdata <= dsau_pkg::ZERO_WORD;
    end else begin
      o_sfr_addr  <= ea & dsau_pkg::ALIGN_MASK;
      o_sfr_we    <= is_sfr ? lane_we : 2'b00;
      o_sfr_rd    <= is_sfr && rd_op;
      o_sfr_wdata <= i_byte_op ? {i_wdata[7:0], i_wdata[7:0]} : push_word;
    end
  end

  // error events, registered so the instruction finishes first
  always_ff @(posedge i_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      addr_err_q  <= 1'b0;
      stack_err_q <= 1'b0;
    end else begin
      addr_err_q  <= misalign;   // trap after the access
      stack_err_q <= stack_err;
    end
  end

  trap_request u_addr_trap (
    .i_clk   (i_clk),
    .i_rst_n (rst_s_q),
    .i_event (addr_err_q),
    .i_ack   (i_addr_trap_ack),
    .o_req   (o_addr_trap)
  );
  trap_request u_stack_trap (
    .i_clk   (i_clk),
    .i_rst_n (rst_s_q),
    .i_event (stack_err_q),
    .i_ack   (i_stack_trap_ack),
    .o_req   (o_stack_trap)
  );
endmodule
`default_nettype wire

// >>> verilog/dsau_pkg.sv
// package for the data-space access unit: address map, widths, stack bounds
// assumes a 16-bit core with byte-granular effective addresses
package dsau_pkg;
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 16;
  localparam int BYTE_W      = 8;
  localparam int WORD_IDX_W  = 10;                     // 2 KB of ram = 1024 words
  localparam int RAM_WORDS   = 1024;
  localparam int WINDOW_BIT  = 15;                     // upper half is program window
  localparam int NEAR_W      = 13;                     // near-region direct field width
  localparam int PAGE_W      = 8;
  localparam int PROG_ADDR_W = 23;
  localparam logic [15:0] SFR_LAST   = 16'h07FF;
  localparam logic [15:0] RAM_FIRST  = 16'h0800;       // stack underflow bound
  localparam logic [15:0] RAM_END    = 16'h1000;       // first byte past ram
  localparam logic [15:0] NEAR_LAST  = 16'h1FFF;
  localparam logic [15:0] BYTE_STEP  = 16'h0001;
  localparam logic [15:0] WORD_STEP  = 16'h0002;
  localparam logic [15:0] ZERO_WORD  = 16'h0000;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;
  localparam logic [15:0] ALIGN_MASK = 16'hFFFE;

  // operation the pipeline requests
  typedef enum logic [2:0] {
    OP_IDLE   = 3'h0,
    OP_READ   = 3'h1,
    OP_WRITE  = 3'h2,
    OP_PUSH   = 3'h3,
    OP_POP    = 3'h4,
    OP_SEXT   = 3'h5,
    OP_ZEXT   = 3'h6,
    OP_SETLIM = 3'h7
  } op_t;

  // addressing mode of the effective address
  typedef enum logic [1:0] {
    AM_NEAR     = 2'h0,
    AM_DIRECT   = 2'h1,
    AM_INDIRECT = 2'h2,
    AM_POSTINC  = 2'h3
  } amode_t;

  // trap request state, gray coded
  typedef enum logic [1:0] {
    TR_IDLE = 2'b00,
    TR_PEND = 2'b01,
    TR_HOLD = 2'b11
  } trap_st_t;
endpackage

// >>> verilog/trap_request.sv
// one held trap request toward the exception logic
// assumes the exception logic pulses i_ack when it takes the trap
`timescale 1ns/1ns
`default_nettype none
module trap_request (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // event and acceptance
  input  wire logic i_event,
  input  wire logic i_ack,
  // request
  output logic      o_req
);
  dsau_pkg::trap_st_t st_q;

  // new event beats ack so a trap raised in the accept cycle stays pending
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= dsau_pkg::TR_IDLE;
    end else begin
      case (st_q)
        dsau_pkg::TR_IDLE: begin
          if (i_event) st_q <= dsau_pkg::TR_PEND;
        end
        dsau_pkg::TR_PEND: begin
          st_q <= dsau_pkg::TR_HOLD;
          if (i_ack && !i_event) st_q <= dsau_pkg::TR_IDLE;
        end
        dsau_pkg::TR_HOLD: begin
          if (i_ack && !i_event) st_q <= dsau_pkg::TR_IDLE;
        end
        default: st_q <= dsau_pkg::TR_IDLE;
      endcase
    end
  end

  // bit 0 is set in both waiting states, so the request is a plain flop output
  assign o_req = st_q[0];
endmodule
`default_nettype wire

// >>> test/dsau_chk_sva.sv
// checker for the data-space access unit, watching top-level ports only
// assumes requests are spaced so the stack pointer port has settled
`timescale 1ns/1ns
`default_nettype none
module dsau_chk (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rstn,
  // request side
  input wire logic        i_valid,
  input wire logic [2:0]  i_op,
  input wire logic [1:0]  i_amode,
  input wire logic        i_byte_op,
  input wire logic [15:0] i_addr_field,
  input wire logic [15:0] i_source_pointer_reg,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] i_dest_reg_old,
  input wire logic [7:0]  i_program_window_page,
  input wire logic        i_addr_trap_ack,
  // answer side
  input wire logic [15:0] o_reg_result,
  input wire logic [15:0] o_source_pointer_next,
  input wire logic [15:0] o_stack_pointer_reg,
  input wire logic [15:0] o_stack_limit_reg,
  input wire logic [22:0] o_prog_addr,
  input wire logic        o_prog_rd,
  input wire logic [1:0]  o_sfr_we,
  input wire logic [15:0] o_sfr_wdata,
  input wire logic        o_addr_trap,
  input wire logic        o_stack_trap
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // direct mode names the byte address outright, so lanes can be predicted
  wire logic dir = i_valid && i_amode == dsau_pkg::AM_DIRECT;
  wire logic rw  = i_op == dsau_pkg::OP_READ || i_op == dsau_pkg::OP_WRITE;
  wire logic special_function_region = i_addr_field < 16'h0800;

  chk_byte_lane: assert property (
    dir && i_op == dsau_pkg::OP_WRITE && i_byte_op && special_function_region
    |=> o_sfr_we == {$past(i_addr_field[0]), !$past(i_addr_field[0])}
        && o_sfr_wdata == {2{$past(i_wdata[7:0])}})
    else $error("byte write strobe on wrong lane");
  chk_odd_word: assert property (
    dir && rw && !i_byte_op && i_addr_field[0] |-> ##2 o_addr_trap)
    else $error("odd word access raised no address trap");
  chk_trap_held: assert property (
    o_addr_trap && !i_addr_trap_ack |=> o_addr_trap)
    else $error("address trap dropped before acceptance");
  chk_limit_even: assert property (
    o_stack_limit_reg[0] == 1'b0) else $error("stack limit bit 0 set");
  chk_window_map: assert property (
    dir && i_op == dsau_pkg::OP_READ && i_addr_field[15]
    |=> o_prog_rd
        && o_prog_addr == {$past(i_program_window_page), $past(i_addr_field[14:1]), 1'b0})
    else $error("window read went to wrong program address");
  chk_post_step: assert property (
    i_valid && i_amode == dsau_pkg::AM_POSTINC && rw
    |=> o_source_pointer_next == $past(i_source_pointer_reg) + ($past(i_byte_op) ? 16'h0001 : 16'h0002))
    else $error("post-increment step wrong");
  chk_sign_ext: assert property (
    i_valid && i_op == dsau_pkg::OP_SEXT
    |=> o_reg_result == {{8{$past(i_wdata[7])}}, $past(i_wdata[7:0])})
    else $error("sign extension wrong");
  chk_byte_keep: assert property (
    i_valid && i_op == dsau_pkg::OP_READ && i_byte_op
    |-> ##2 o_reg_result[15:8] == $past(i_dest_reg_old[15:8], 2))
    else $error("byte load changed the high byte");
  chk_underflow: assert property (
    i_valid && i_op == dsau_pkg::OP_POP && o_stack_pointer_reg < 16'h0802 |-> ##2 o_stack_trap)
    else $error("stack underflow not trapped");
  chk_over_limit: assert property (
    i_valid && i_op == dsau_pkg::OP_PUSH && o_stack_pointer_reg > o_stack_limit_reg
    |-> ##2 o_stack_trap) else $error("push past limit not trapped");
endmodule
bind data_space_access_unit dsau_chk chk (.*);
`default_nettype wire

// >>> test/dsau_far_side.sv
// far-side model: special region, program window and trap acceptance
// assumes reads are answered in the cycle the design raises its read strobe
`timescale 1ns/1ns
`default_nettype none
module dsau_far_side (
  // clock and pace
  input  wire logic        i_clk,
  input  wire logic        i_slow,
  // special region and window
  input  wire logic        i_sfr_rd,
  input  wire logic [15:0] i_sfr_addr,
  input  wire logic        i_prog_rd,
  input  wire logic [22:0] i_prog_addr,
  output logic      [15:0] o_sfr_rdata,
  output logic             o_sfr_hit,
  output logic      [15:0] o_prog_rdata,
  // trap requests, stack in bit 1
  input  wire logic [1:0]  i_trap,
  output logic      [1:0]  o_ack
);
  logic [15:0] pat_q = 16'h1234;
  logic [1:0]  ack_q = 2'b00;
  logic [2:0]  cnt_q [2] = '{3'h0, 3'h0};
  // idle lines show a running pattern so stale data never passes
  always @(posedge i_clk) pat_q <= pat_q * 16'h0005 + 16'h3A71;
  // only the low 256 bytes are implemented registers
  assign o_sfr_hit    = i_sfr_rd && i_sfr_addr < 16'h0100;
  assign o_sfr_rdata  = o_sfr_hit ? (i_sfr_addr & 16'hFFFE) ^ 16'h5A5A : pat_q;
  assign o_prog_rdata = i_prog_rd ? i_prog_addr[15:0] ^ 16'h3C3C : pat_q;
  assign o_ack        = ack_q;
  always @(posedge i_clk) begin
    for (int k = 0; k < 2; k++) begin
      ack_q[k] <= i_trap[k] && !ack_q[k] && cnt_q[k] == (i_slow ? 3'h3 : 3'h0);
      cnt_q[k] <= (i_trap[k] && !ack_q[k]) ? cnt_q[k] + 3'h1 : 3'h0;
    end
  end
endmodule
`default_nettype wire

// >>> test/data_space_access_unit_test.sv
// self-checking bench for the data-space access unit
// assumes the far-side model answers reads and accepts traps
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s: expected %h seen %h", n, e, g); end end
module data_space_access_unit_test;
  localparam logic [2:0] RD = dsau_pkg::OP_READ, WR = dsau_pkg::OP_WRITE;
  localparam logic [2:0] PU = dsau_pkg::OP_PUSH, PO = dsau_pkg::OP_POP, SL = dsau_pkg::OP_SETLIM;
  localparam logic [2:0] SX = dsau_pkg::OP_SEXT, ZX = dsau_pkg::OP_ZEXT;
  localparam logic [1:0] DI = dsau_pkg::AM_DIRECT;
  logic        i_clk = 1'b0, i_rstn = 1'b0, i_valid = 1'b0, i_byte_op = 1'b0, i_slow = 1'b0;
  logic [2:0]  i_op = 3'h0;
  logic [1:0]  i_amode = 2'h0;
  logic [15:0] i_addr_field = '0, i_source_pointer_reg = '0, i_wdata = '0, i_dest_reg_old = '0;
  logic        i_exception_push = 1'b0, i_exec_boot_seg = 1'b0, i_exec_app_seg = 1'b0;
  logic [22:0] i_pc = '0, o_prog_addr;
  logic [7:0]  i_status_low_byte = '0, i_program_window_page = '0;
  logic [15:0] i_sfr_rdata, i_prog_rdata, i_boot_ram_start = '0, i_app_ram_start = '0;
  logic        i_sfr_hit, i_boot_ram_en = 1'b0, i_app_ram_en = 1'b0;
  logic        i_addr_trap_ack, i_stack_trap_ack, at_q, st_q;
  logic        o_done, o_prog_rd, o_sfr_rd, o_addr_trap, o_stack_trap;
  logic [15:0] o_rdata, o_reg_result, o_source_pointer_next, o_stack_pointer_reg;
  logic [15:0] o_stack_limit_reg, o_sfr_addr, o_sfr_wdata, a, w, d;
  logic [1:0]  o_sfr_we;
  logic [16:0] exp_q [$];
  int          n_errors = 0, comparisons = 0, n, n_at = 0, n_st = 0;

  data_space_access_unit dut (.*);
  dsau_far_side far (.i_clk(i_clk), .i_slow(i_slow), .i_sfr_rd(o_sfr_rd),
    .i_sfr_addr(o_sfr_addr), .i_prog_rd(o_prog_rd), .i_prog_addr(o_prog_addr),
    .o_sfr_rdata(i_sfr_rdata), .o_sfr_hit(i_sfr_hit), .o_prog_rdata(i_prog_rdata),
    .i_trap({o_stack_trap, o_addr_trap}), .o_ack({i_stack_trap_ack, i_addr_trap_ack}));

  always #50 i_clk = ~i_clk;

  // byte reads land in the low lane with the high lane cleared
  function automatic logic [15:0] pick(input logic [15:0] v, input logic odd);
    pick = {8'h00, odd ? v[15:8] : v[7:0]};
  endfunction

  // one request, noted with its expected read data; c says whether to compare
  task automatic req(input logic [2:0] op, input logic [1:0] am, input logic b,
                     input logic [15:0] ad, input logic [15:0] dt, input logic [15:0] e,
                     input logic c);
    @(posedge i_clk);
    #10;
    i_valid = 1'b1;
    i_op = op;
    i_amode = am;
    i_byte_op = b;
    i_addr_field = ad;
    i_source_pointer_reg = ad;
    i_wdata = dt;
    i_dest_reg_old = 16'($urandom);
    exp_q.push_back({c, e});
    @(posedge i_clk);
    #10;
    i_valid = 1'b0;
    if (op == SX || op == ZX) `CHK("reg result", e, o_reg_result)
    repeat (2) @(posedge i_clk);
    #10;
  endtask

  task automatic rst;
    i_rstn = 1'b0;
    repeat (16) @(posedge i_clk);
    #10;
    i_rstn = 1'b1;
    repeat (3) @(posedge i_clk);
    #10;
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // oldest note against each done pulse; trap rises are counted beside it
  always @(posedge i_clk) begin
    at_q <= o_addr_trap;
    st_q <= o_stack_trap;
    if (o_addr_trap === 1'b1 && at_q !== 1'b1) n_at++;
    if (o_stack_trap === 1'b1 && st_q !== 1'b1) n_st++;
    if (o_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("unexpected done: expected none seen 1");
      end else begin
        if (exp_q[0][16]) `CHK("read data", exp_q[0][15:0], o_rdata)
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    #200_000; // several times the expected run length
    n_errors++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    n = $urandom(51);
    rst();
    // ram words and bytes through every addressing mode
    for (int m = 0; m < 4; m++) begin
      a = 16'h0800 + {5'h00, 10'($urandom % 640), 1'b0};
      w = 16'($urandom);
      d = 16'($urandom);
      req(WR, 2'(m), 0, a, w, 0, 0);
      req(RD, 2'(m), 0, a, 0, w, 1);
      req(RD, 2'(m), 1, a + 16'h0001, 0, pick(w, 1), 1);
      req(WR, 2'(m), 1, a + 16'h0001, {d[7:0], d[7:0]}, 0, 0);
      req(RD, 2'(m), 0, a, 0, {d[7:0], w[7:0]}, 1);
    end
    a = 16'h1000 + (16'($urandom) & 16'h6FFE);
    req(RD, DI, 0, a, 0, 16'h0000, 1);
    req(RD, DI, 1, a + 16'h0001, 0, 16'h0000, 1);
    $display("ram test done");
    // special region: implemented, empty, and byte strobes
    req(RD, DI, 0, 16'h0010, 0, 16'h0010 ^ 16'h5A5A, 1);
    req(RD, DI, 1, 16'h0011, 0, pick(16'h0010 ^ 16'h5A5A, 1), 1);
    req(RD, DI, 0, 16'h0400, 0, 16'h0000, 1);
    req(WR, DI, 1, 16'h0021, w, 0, 0);
    req(WR, DI, 1, 16'h0020, w, 0, 0);
    // program window through a random page
    i_program_window_page = 8'($urandom);
    a = 16'h8000 | (16'($urandom) & 16'h7FFE);
    w = {i_program_window_page[0], a[14:0]} ^ 16'h3C3C;
    req(RD, DI, 0, a, 0, w, 1);
    req(RD, DI, 1, a | 16'h0001, 0, pick(w, 1), 1);
    $display("region test done");
    // odd word accesses trap; the write is dropped
    a = 16'h0820;
    w = 16'($urandom);
    n = n_at;
    req(WR, DI, 0, a, w, 0, 0);
    req(WR, DI, 0, a + 16'h0001, ~w, 0, 0);
    req(RD, DI, 0, a, 0, w, 1);
    req(RD, DI, 0, a + 16'h0001, 0, 16'h0000, 1);
    `CHK("address traps", n + 2, n_at)
    for (int k = 0; k < 4; k++) begin
      d = {8'($urandom), k[0], 7'($urandom)};
      req(SX, DI, 0, 0, d, {{8{d[7]}}, d[7:0]}, 0);
      req(ZX, DI, 0, 0, d, {8'h00, d[7:0]}, 0);
    end
    $display("align test done");
    // secure segments: own code only, others read zero and cannot write
    for (int k = 0; k < 2; k++) begin
      i_boot_ram_en = (k == 0);
      i_app_ram_en = (k == 1);
      i_boot_ram_start = 16'h0F00;
      i_app_ram_start = 16'h0F00;
      w = 16'($urandom);
      i_exec_boot_seg = (k == 0);
      i_exec_app_seg = (k == 1);
      req(WR, DI, 0, 16'h0F10, w, 0, 0);
      i_exec_boot_seg = 1'b0;
      i_exec_app_seg = 1'b0;
      req(WR, DI, 0, 16'h0F10, ~w, 0, 0);
      req(RD, DI, 0, 16'h0F10, 0, 16'h0000, 1);
      i_exec_boot_seg = (k == 0);
      i_exec_app_seg = (k == 1);
      req(RD, DI, 0, 16'h0F10, 0, w, 1);
    end
    $display("secure test done");
    // stack: plain and exception pushes, pops, then underflow
    i_slow = 1'b1;
    i_pc = 23'($urandom);
    i_status_low_byte = 8'($urandom);
    w = 16'($urandom);
    req(SL, DI, 0, 0, 16'h0FFE, 0, 0);
    req(PU, DI, 0, 0, w, 0, 0);
    `CHK("stack pointer", 16'h0802, o_stack_pointer_reg)
    i_exception_push = 1'b1;
    req(PU, DI, 0, 0, 0, 0, 0);
    i_exception_push = 1'b0;
    req(PO, DI, 0, 0, 0, {i_status_low_byte, 1'b0, i_pc[22:16]}, 1);
    req(PO, DI, 0, 0, 0, w, 1);
    `CHK("stack pointer", 16'h0800, o_stack_pointer_reg)
    n = n_st;
    req(PO, DI, 0, 0, 0, 0, 0);
    `CHK("stack traps", n + 1, n_st)
    // mid-run reset, then pushes up to and past the limit
    rst();
    `CHK("stack pointer", 16'h0800, o_stack_pointer_reg)
    req(SL, DI, 0, 0, 16'h0803, 0, 0);
    `CHK("stack limit", 16'h0802, o_stack_limit_reg)
    n = n_st;
    req(PU, DI, 0, 0, w, 0, 0);
    req(PU, DI, 0, 0, w, 0, 0);
    `CHK("stack traps", n, n_st)
    req(PU, DI, 0, 0, w, 0, 0);
    `CHK("stack traps", n + 1, n_st)
    $display("stack test done");
    end_of_test();
  end
endmodule
`default_nettype wire
